/* verilog/dacmc_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - attenuation gain is half a decibel times code minus 255
// - codes 0 through 128 give full mute
// - applied level moves one step per eight samples toward target
// - both attenuation fields reset to all ones
// - left and right attenuation programmed independently
// - soft mute set ramps level down to mute stepwise
// - soft mute clear ramps level back to programmed value
// - mute bits reset clear; clear means normal operation
// - oversampling bit picks double rate; resets clear
// - soft reset bit restores all mode registers to defaults
// - disable bit forces channel output to mid-scale
// - deemphasis enable bit switches filter; resets clear
// - deemphasis rate field selects 44.1, 48 or 32 kHz
// - format codes 000 to 011 are right-justified 24/20/18/16 bits
// - codes 100 I2S, 101 left-justified default, others reserved
// - control word is sixteen bits msb first: zero, index, data
// - latch low, sixteen clocks, latch high commits the word
module dacmc_regs
  import dacmc_pkg::*;
#(
  parameter int SAMPLE_DIV = 256
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        control_shift_clock,
  input  wire logic        control_serial_in,
  input  wire logic        control_latch,
  input  wire logic        sample_tick,
  output logic [7:0]       left_atten_applied_q,
  output logic [7:0]       right_atten_applied_q,
  output logic             left_muted_q,
  output logic             right_muted_q,
  output logic             left_output_disable_q,
  output logic             right_output_disable_q,
  output logic             oversample_double_q,
  output logic             deemph_enable_q,
  output logic [1:0]       deemph_rate_select_q,
  output logic [2:0]       audio_format_code_q,
  output logic [4:0]       format_word_length_q,
  output logic             format_i2s_q,
  output logic             format_left_just_q
);
  logic [WORD_BITS-1:0] word_w;
  logic                 ok_w;
  logic [WORD_BITS-1:0] word_s1_q;
  logic [WORD_BITS-1:0] word_s2_q;
  logic                 ok_s1_q;
  logic                 ok_s2_q;
  logic                 lat_s1_q;
  logic                 lat_s2_q;
  logic                 lat_s3_q;
  logic                 wr_q;
  logic [WORD_BITS-1:0] wr_word_q;
  logic                 samp_s1_q;
  logic                 samp_s2_q;
  logic                 samp_s3_q;
  logic [7:0]           atten_target_q [2];
  logic [7:0]           atten_applied_q [2];
  logic [1:0]           channel_soft_mute_q;
  logic [1:0]           channel_output_disable_q;
  logic [2:0]           step_count_q;
  logic                 step_w;
  logic [6:0]           register_index;
  logic [7:0]           data_w;

  dacmc_serial_rx u_rx (
    .control_shift_clock (control_shift_clock),
    .control_serial_in   (control_serial_in),
    .control_latch       (control_latch),
    .word_q              (word_w),
    .word_ok_q           (ok_w)
  );

  // latch pin synchronised; idle level is high so reset gives no false rise
  always_ff @(posedge clk) begin
    if (rst) begin
      lat_s1_q <= 1'b1;
      lat_s2_q <= 1'b1;
      lat_s3_q <= 1'b1;
    end else if (clk_en) begin
      lat_s1_q <= control_latch;
      lat_s2_q <= lat_s1_q;
      lat_s3_q <= lat_s2_q;
    end
  end

  // word and valid flag through two stages; word reloaded every enabled cycle, write strobed when latch rise seen
  always_ff @(posedge clk) begin
    if (rst) begin
      word_s1_q <= '0;
      word_s2_q <= '0;
      ok_s1_q   <= 1'b0;
      ok_s2_q   <= 1'b0;
      wr_q      <= 1'b0;
      wr_word_q <= '0;
    end else if (clk_en) begin
      word_s1_q <= word_w;
      word_s2_q <= word_s1_q;
      ok_s1_q   <= ok_w;
      ok_s2_q   <= ok_s1_q;
      wr_q      <= lat_s2_q && !lat_s3_q && ok_s2_q;
      wr_word_q <= word_s2_q;
    end
  end

  assign register_index = wr_word_q[IDX_MSB:IDX_LSB];
  assign data_w         = wr_word_q[7:0];

  // sample-rate tick from audio side, synchronised and edge detected
  always_ff @(posedge clk) begin
    if (rst) begin
      samp_s1_q <= 1'b0;
      samp_s2_q <= 1'b0;
      samp_s3_q <= 1'b0;
    end else if (clk_en) begin
      samp_s1_q <= sample_tick;
      samp_s2_q <= samp_s1_q;
      samp_s3_q <= samp_s2_q;
    end
  end

  // eight sample periods per ramp step
  always_ff @(posedge clk) begin
    if (rst) begin
      step_count_q <= 3'h0;
    end else if (clk_en && samp_s2_q && !samp_s3_q) begin
      step_count_q <= step_count_q + 3'h1;
    end
  end
  assign step_w = samp_s2_q && !samp_s3_q && (step_count_q == 3'(RAMP_SAMPLES - 1));

  // soft reset: a write with the reset bit restores the targets and mode registers to defaults
  // attenuation targets, per channel
  always_ff @(posedge clk) begin
    if (rst) begin
      atten_target_q[0] <= ATTEN_RESET;
      atten_target_q[1] <= ATTEN_RESET;
    end else if (clk_en && wr_q && !wr_word_q[WORD_BITS-1]) begin
      if (register_index == IDX_MUTE_OVER && data_w[POS_SOFT_RESET_REQUEST]) begin
        atten_target_q[0] <= ATTEN_RESET;
        atten_target_q[1] <= ATTEN_RESET;
      end else if (register_index == IDX_LEFT_ATTEN) begin
        atten_target_q[0] <= data_w;
      end else if (register_index == IDX_RIGHT_ATTEN) begin
        atten_target_q[1] <= data_w;
      end
    end
  end

  // mode bits; unknown indices fall through unchanged
  always_ff @(posedge clk) begin
    if (rst) begin
      channel_soft_mute_q      <= 2'h0;
      oversample_double_q      <= 1'b0;
      channel_output_disable_q <= 2'h0;
      deemph_enable_q          <= 1'b0;
      deemph_rate_select_q     <= DMF_RESET;
      audio_format_code_q      <= FMT_RESET;
    end else if (clk_en && wr_q && !wr_word_q[WORD_BITS-1]) begin
      if (register_index == IDX_MUTE_OVER) begin
        if (data_w[POS_SOFT_RESET_REQUEST]) begin
          channel_soft_mute_q      <= 2'h0;
          oversample_double_q      <= 1'b0;
          channel_output_disable_q <= 2'h0;
          deemph_enable_q          <= 1'b0;
          deemph_rate_select_q     <= DMF_RESET;
          audio_format_code_q      <= FMT_RESET;
        end else begin
          channel_soft_mute_q <= {data_w[POS_MUTE_R], data_w[POS_MUTE_L]};
          oversample_double_q <= data_w[POS_OVER];
        end
      end else if (register_index == IDX_DAC_DEEMPH) begin
        channel_output_disable_q <= {data_w[POS_DIS_R], data_w[POS_DIS_L]};
        deemph_enable_q          <= data_w[POS_DEEMPH_EN];
        deemph_rate_select_q     <= data_w[POS_DMF_LSB +: 2];
      end else if (register_index == IDX_FORMAT) begin
        audio_format_code_q <= data_w[POS_FMT_LSB +: 3];
      end
    end
  end

  // per-channel ramp toward target, or toward mute while soft muted
  for (genvar ch = 0; ch < 2; ch++) begin : g_ramp
    logic [7:0] goal_w;
    // codes at or below the mute top all count as mute
    assign goal_w = (channel_soft_mute_q[ch] || atten_target_q[ch] <= ATTEN_MUTE_TOP) ?
                    ATTEN_MUTE_TOP : atten_target_q[ch];
    always_ff @(posedge clk) begin
      if (rst) begin
        atten_applied_q[ch] <= ATTEN_RESET;
      end else if (clk_en && step_w) begin
        if (atten_applied_q[ch] < goal_w) begin
          atten_applied_q[ch] <= atten_applied_q[ch] + 8'h01;
        end else if (atten_applied_q[ch] > goal_w) begin
          atten_applied_q[ch] <= atten_applied_q[ch] - 8'h01;
        end
      end
    end
  end

  // registered outputs to the audio datapath; gain step = applied-255 half dB
  always_ff @(posedge clk) begin
    if (rst) begin
      left_atten_applied_q   <= ATTEN_RESET;
      right_atten_applied_q  <= ATTEN_RESET;
      left_muted_q           <= 1'b0;
      right_muted_q          <= 1'b0;
      left_output_disable_q  <= 1'b0;
      right_output_disable_q <= 1'b0;
    end else if (clk_en) begin
      left_atten_applied_q   <= atten_applied_q[0];
      right_atten_applied_q  <= atten_applied_q[1];
      left_muted_q           <= atten_applied_q[0] <= ATTEN_MUTE_TOP;
      right_muted_q          <= atten_applied_q[1] <= ATTEN_MUTE_TOP;
      left_output_disable_q  <= channel_output_disable_q[0];
      right_output_disable_q <= channel_output_disable_q[1];
    end
  end

  // format decode for the audio receiver
  always_ff @(posedge clk) begin
    if (rst) begin
      format_word_length_q <= 5'h18;
      format_i2s_q         <= 1'b0;
      format_left_just_q   <= 1'b1;
    end else if (clk_en) begin
      format_i2s_q       <= audio_format_code_q == FMT_I2S;
      format_left_just_q <= audio_format_code_q == FMT_LJ;
      case (audio_format_code_q)
        FMT_RJ20: format_word_length_q <= 5'h14;
        FMT_RJ18: format_word_length_q <= 5'h12;
        FMT_RJ16: format_word_length_q <= 5'h10;
        default:  format_word_length_q <= 5'h18;
      endcase
    end
  end
endmodule
`default_nettype wire

/* common/dacmc_pkg.sv */
package dacmc_pkg;
  // register indices carried in the control word
  localparam logic [6:0] IDX_LEFT_ATTEN   = 7'h10;
  localparam logic [6:0] IDX_RIGHT_ATTEN  = 7'h11;
  localparam logic [6:0] IDX_MUTE_OVER    = 7'h12;
  localparam logic [6:0] IDX_DAC_DEEMPH   = 7'h13;
  localparam logic [6:0] IDX_FORMAT       = 7'h14;
  // control word layout
  localparam int         WORD_BITS        = 16;
  localparam int         IDX_MSB          = 14;
  localparam int         IDX_LSB          = 8;
  // field positions
  localparam int         POS_MUTE_L       = 0;
  localparam int         POS_MUTE_R       = 1;
  localparam int         POS_OVER         = 6;
  localparam int         POS_SOFT_RESET_REQUEST         = 7;
  localparam int         POS_DIS_L        = 0;
  localparam int         POS_DIS_R        = 1;
  localparam int         POS_DEEMPH_EN    = 4;
  localparam int         POS_DMF_LSB      = 5;
  localparam int         POS_FMT_LSB      = 0;
  // reset values and mute threshold
  localparam logic [7:0] ATTEN_RESET      = 8'hFF;
  localparam logic [7:0] ATTEN_MUTE_TOP   = 8'h80;
  localparam logic [1:0] DMF_RESET        = 2'h0;
  localparam logic [2:0] FMT_RESET        = 3'h5;
  // deemphasis rates
  localparam logic [1:0] DMF_44K1         = 2'h0;
  localparam logic [1:0] DMF_48K          = 2'h1;
  localparam logic [1:0] DMF_32K          = 2'h2;
  // format codes
  localparam logic [2:0] FMT_RJ24         = 3'h0;
  localparam logic [2:0] FMT_RJ20         = 3'h1;
  localparam logic [2:0] FMT_RJ18         = 3'h2;
  localparam logic [2:0] FMT_RJ16         = 3'h3;
  localparam logic [2:0] FMT_I2S          = 3'h4;
  localparam logic [2:0] FMT_LJ           = 3'h5;
  // ramp timing: sample periods per attenuator step
  localparam int         RAMP_SAMPLES     = 8;
endpackage

/* verilog/dacmc_serial_rx.sv */
`timescale 1ns/1ps
`default_nettype none
// shift register on the control shift clock; word and its validity latched on latch rise
module dacmc_serial_rx
  import dacmc_pkg::*;
(
  input  wire logic                 control_shift_clock,
  input  wire logic                 control_serial_in,
  input  wire logic                 control_latch,
  output logic [WORD_BITS-1:0]      word_q,
  output logic                      word_ok_q
);
  logic [WORD_BITS-1:0] shift_q;
  logic [4:0]           count_q;

  // shift msb first on every shift clock rise
  always_ff @(posedge control_shift_clock) begin
    shift_q <= {shift_q[WORD_BITS-2:0], control_serial_in};
  end

  // clocks seen since latch fell; latch high holds the count at zero
  always_ff @(posedge control_shift_clock or posedge control_latch) begin
    if (control_latch) begin
      count_q <= 5'h00;
    end else if (count_q != 5'h1F) begin
      count_q <= count_q + 5'h01;
    end
  end

  // latch rise commits only a frame of exactly sixteen clocks
  // a level flag instead of a toggle needs no reset on this side
  always_ff @(posedge control_latch) begin
    word_ok_q <= count_q == 5'(WORD_BITS);
    if (count_q == 5'(WORD_BITS)) begin
      word_q <= shift_q;
    end
  end
endmodule
`default_nettype wire

/* test/dacmc_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module dacmc_regs_asserts
  import dacmc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] left_atten_applied_q,
  input wire logic [7:0] right_atten_applied_q,
  input wire logic       left_muted_q,
  input wire logic [2:0] audio_format_code_q,
  input wire logic [4:0] format_word_length_q,
  input wire logic       format_i2s_q,
  input wire logic       format_left_just_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] gap_q;
  logic       seen_q;
  // cycles since the last step of the left level
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_q  <= 8'h00;
      seen_q <= 1'b0;
    end else if ($changed(left_atten_applied_q)) begin
      gap_q  <= 8'h00;
      seen_q <= 1'b1;
    end else if (gap_q != 8'hFF) begin
      gap_q <= gap_q + 8'h01;
    end
  end
  // level unchanged long enough for the flag to follow
  sequence left_held;
    $stable(left_atten_applied_q) ##1 $stable(left_atten_applied_q);
  endsequence
  // two quiet cycles cover one frozen clock-enable cycle in the decode stage
  sequence fmt_held;
    $stable(audio_format_code_q) ##1 $stable(audio_format_code_q);
  endsequence
  level_step_a: assert property ($changed(left_atten_applied_q) && !$past(rst) |->
    (left_atten_applied_q - $past(left_atten_applied_q)) inside {8'h01, 8'hFF}) else $error("level jumped");
  step_gap_a: assert property ($changed(left_atten_applied_q) && seen_q |-> gap_q >= 8'h1C)
    else $error("level stepped too soon");
  level_floor_a: assert property (left_atten_applied_q >= ATTEN_MUTE_TOP &&
    right_atten_applied_q >= ATTEN_MUTE_TOP) else $error("level below mute code");
  mute_flag_a: assert property (left_held |-> left_muted_q == (left_atten_applied_q <= ATTEN_MUTE_TOP))
    else $error("mute flag wrong");
  reset_level_a: assert property ($fell(rst) |-> left_atten_applied_q == ATTEN_RESET &&
    right_atten_applied_q == ATTEN_RESET && !left_muted_q) else $error("level not reset");
  reset_format_a: assert property ($fell(rst) |-> audio_format_code_q == FMT_RESET)
    else $error("format not reset");
  word_length_a: assert property (fmt_held |-> format_word_length_q ==
    (audio_format_code_q == FMT_RJ20 ? 5'h14 : audio_format_code_q == FMT_RJ18 ? 5'h12 :
    audio_format_code_q == FMT_RJ16 ? 5'h10 : 5'h18)) else $error("word length wrong");
  format_flags_a: assert property (fmt_held |-> format_i2s_q == (audio_format_code_q == FMT_I2S) &&
    format_left_just_q == (audio_format_code_q == FMT_LJ)) else $error("format flags wrong");
endmodule
bind dacmc_regs dacmc_regs_asserts dacmc_regs_asserts_inst (.clk(clk), .rst(rst),
  .left_atten_applied_q(left_atten_applied_q), .right_atten_applied_q(right_atten_applied_q),
  .left_muted_q(left_muted_q), .audio_format_code_q(audio_format_code_q),
  .format_word_length_q(format_word_length_q), .format_i2s_q(format_i2s_q),
  .format_left_just_q(format_left_just_q));
`default_nettype wire

/* test/dacmc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module dacmc_host (
  output logic control_shift_clock,
  output logic control_serial_in,
  output logic control_latch
);
  // idle: latch high, shift clock parked
  initial begin
    control_shift_clock = 1'b0;
    control_serial_in   = 1'b0;
    control_latch       = 1'b1;
  end
  // one write: latch low, sixteen bits msb first, latch rise commits
  task automatic send(input logic [15:0] w);
    int i;
    #2.7 control_latch = 1'b0;
    for (i = 15; i >= 0; i--) begin
      control_serial_in = w[i];
      #6 control_shift_clock = 1'b1;
      #6 control_shift_clock = 1'b0;
    end
    #6 control_serial_in = ~control_serial_in;
    control_latch = 1'b1;
    #150;
  endtask
endmodule
`default_nettype wire

/* test/tb_dacmc_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_dacmc_regs;
  import dacmc_pkg::*;
  logic            clk, rst;
  logic            clk_en      = 1'b1;
  logic            sample_tick = 1'b0;
  logic [3:0]      tick_cnt    = 4'h0;
  logic [7:0]      lv;
  wire logic       sck, sdi, lat, l_mu, r_mu, l_dis, r_dis, over, dm_en, i2s, lj;
  wire logic [7:0] l_att, r_att;
  wire logic [1:0] dm_rate;
  wire logic [2:0] fmt;
  wire logic [4:0] wlen;
  int              seed, n_fail, n_compared, i;
  dacmc_host dacmc_host_inst (.control_shift_clock(sck), .control_serial_in(sdi), .control_latch(lat));
  dacmc_regs dacmc_regs_inst (.clk(clk), .rst(rst), .clk_en(clk_en), .control_shift_clock(sck),
    .control_serial_in(sdi), .control_latch(lat), .sample_tick(sample_tick), .left_atten_applied_q(l_att),
    .right_atten_applied_q(r_att), .left_muted_q(l_mu), .right_muted_q(r_mu), .left_output_disable_q(l_dis),
    .right_output_disable_q(r_dis), .oversample_double_q(over), .deemph_enable_q(dm_en),
    .deemph_rate_select_q(dm_rate), .audio_format_code_q(fmt), .format_word_length_q(wlen),
    .format_i2s_q(i2s), .format_left_just_q(lj));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // sample ticks every four cycles, clock enable dropped now and then
  always @(negedge clk) begin
    tick_cnt <= tick_cnt + 4'h1;
    sample_tick <= tick_cnt[1];
    clk_en <= rst || tick_cnt != 4'hB;
  end
  function automatic logic [7:0] exp_len(input logic [2:0] c);
    case (c)
      FMT_RJ20: return 8'h14;
      FMT_RJ18: return 8'h12;
      FMT_RJ16: return 8'h10;
      default:  return 8'h18;
    endcase
  endfunction
  task automatic tally_and_finish();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    dacmc_host_inst.send({1'b0, idx, d});
    repeat (16) @(negedge clk);
  endtask
  task automatic ramp_to(input logic [7:0] el, input logic [7:0] er);
    int k;
    for (k = 0; k < 9000 && (l_att !== el || r_att !== er); k++) @(negedge clk);
    if (k == 9000) begin
      n_fail++;
      $display("[ERR] %0t level wait timed out", $time);
      tally_and_finish();
    end
    repeat (40) @(negedge clk);
    cmp(l_att, el, "left level");
    cmp(r_att, er, "right level");
  endtask
  initial begin
    seed = 23265;
    n_fail = 0;
    n_compared = 0;
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    ramp_to(ATTEN_RESET, ATTEN_RESET);
    cmp({l_mu, r_mu, l_dis, r_dis, over, dm_en, dm_rate}, 8'h00, "mode bits");
    cmp({3'h0, i2s, lj, fmt}, {5'h01, FMT_RESET}, "format");
    cmp(8'(wlen), exp_len(FMT_RESET), "reset length");
    $display("test reset done");
    lv = 8'h81 + 8'({$random(seed)} % 127);
    wr(IDX_LEFT_ATTEN, lv);
    ramp_to(lv, ATTEN_RESET);
    wr(IDX_RIGHT_ATTEN, 8'h40);
    ramp_to(lv, ATTEN_MUTE_TOP);
    cmp({7'h0, r_mu}, 8'h01, "right muted");
    wr(IDX_MUTE_OVER, 8'h01);
    ramp_to(ATTEN_MUTE_TOP, ATTEN_MUTE_TOP);
    wr(IDX_MUTE_OVER, 8'h40);
    ramp_to(lv, ATTEN_MUTE_TOP);
    cmp({7'h0, over}, 8'h01, "oversample");
    $display("test attenuation done");
    for (i = 0; i < 6; i++) begin
      wr(IDX_FORMAT, 8'(i));
      cmp(8'(fmt), 8'(i), "format code");
      cmp(8'(wlen), exp_len(3'(i)), "word length");
      cmp({6'h0, i2s, lj}, {6'h0, 3'(i) == FMT_I2S, 3'(i) == FMT_LJ}, "format flags");
    end
    dacmc_host_inst.send({1'b0, 7'h15, 8'h00});
    dacmc_host_inst.send({1'b1, IDX_FORMAT, 8'h00});
    repeat (16) @(negedge clk);
    cmp(8'(fmt), 8'(FMT_LJ), "refused word");
    $display("test format done");
    for (i = 0; i < 3; i++) begin
      wr(IDX_DAC_DEEMPH, {1'b0, 2'(i), 1'b1, 2'h0, 2'(i + 1)});
      cmp({3'h0, r_dis, l_dis, dm_en, dm_rate}, {3'h0, 2'(i + 1), 1'b1, 2'(i)}, "deemph");
    end
    wr(IDX_FORMAT, 8'(FMT_I2S));
    wr(IDX_MUTE_OVER, 8'h80);
    cmp({2'h0, l_dis, r_dis, over, dm_en, dm_rate}, 8'h00, "soft reset");
    cmp(8'(fmt), 8'(FMT_RESET), "soft reset format");
    ramp_to(ATTEN_RESET, ATTEN_RESET);
    cmp({6'h0, l_mu, r_mu}, 8'h00, "soft reset mute");
    $display("test soft reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
